// ### logic/rtc_cfg_map.vh
// Register map and constants for the clock device configuration bank
//Contract
//- Bank answers index-data access only while unit select 07h holds 10h.
//- Bit 0 of both port base low bytes stays zero despite host writes.
//- Lock bit 7 set: standard RAM 38h-3Fh ignores writes and reads FFh.
//- Lock bit 6 set: every standard and extended RAM write is discarded.
//- Lock bit 5 set: extended RAM 00h-1Fh writes are discarded, reads not.
//- Lock bit 4 set: reads of extended RAM 00h-1Fh return FFh.
//- Lock bit 3 set: all 128 extended RAM bytes ignore writes and read FFh.
//- Writable 7-bit day alarm index resets to 49h; its top bit is reserved.
//- Writable 7-bit month alarm index resets to 4Ah; top bit is reserved.
//- Unused register bits are read-only; host writes to them do nothing.
`ifndef RTC_CFG_MAP_VH
`define RTC_CFG_MAP_VH

// Configuration indices
`define IDX_UNIT_SELECT   8'h07
`define IDX_ACTIVATE      8'h30
`define IDX_PORT0_HIGH    8'h60
`define IDX_PORT0_LOW     8'h61
`define IDX_PORT1_HIGH    8'h62
`define IDX_PORT1_LOW     8'h63
`define IDX_IRQ_NUMBER    8'h70
`define IDX_IRQ_TYPE      8'h71
`define IDX_RAM_LOCK      8'hF0
`define IDX_DAY_ALARM     8'hF1
`define IDX_MONTH_ALARM   8'hF2

// Unit number that selects this bank
`define UNIT_CLOCK        8'h10

// Reset values
`define RST_UNIT_SELECT   8'h00
`define RST_ACTIVATE      8'h00
`define RST_PORT0_HIGH    8'h00
`define RST_PORT0_LOW     8'h70
`define RST_PORT1_HIGH    8'h00
`define RST_PORT1_LOW     8'h72
`define RST_IRQ_NUMBER    8'h08
`define RST_IRQ_TYPE      8'h00
`define RST_RAM_LOCK      5'h00
`define RST_DAY_ALARM     7'h49
`define RST_MONTH_ALARM   7'h4A
// Stored upper seven bits of the base low reset values
`define RST_PORT0_STORED  7'h38
`define RST_PORT1_STORED  7'h39

// Lock register field positions
`define LOCK_STD_UPPER    7
`define LOCK_ALL_WRITE    6
`define LOCK_EXT_LO_WR    5
`define LOCK_EXT_LO_RD    4
`define LOCK_EXT_ALL      3
`define LOCK_LSB          3

// Masks and ranges
`define BASE_ALIGN_MASK   8'hFE
`define STD_UPPER_BASE    7'h38
`define STD_UPPER_TOP     7'h3F
`define EXT_LOW_TOP       7'h1F
`define BLOCKED_READ      8'hFF
`define ZERO_BYTE         8'h00

`endif

// ### logic/rtc_ram_guard.v
// RAM access filter driven by the lock bits
`timescale 1ns/10ps
`default_nettype none
`include "rtc_cfg_map.vh"

module rtc_ram_guard (
  // Lock field, bits 7..3
  input  wire [4:0] lock,
  // Access under test
  input  wire       ext_sel,
  input  wire [6:0] ram_addr,
  // Verdicts
  output wire       write_ok,
  output wire       read_ok
);

  wire std_upper;
  wire ext_low;
  wire b_std;
  wire b_all_wr;
  wire b_ext_lo_wr;
  wire b_ext_lo_rd;
  wire b_ext_all;

  // Lock field indices relative to its lowest bit
  assign b_std       = lock[`LOCK_STD_UPPER - `LOCK_LSB];
  assign b_all_wr    = lock[`LOCK_ALL_WRITE - `LOCK_LSB];
  assign b_ext_lo_wr = lock[`LOCK_EXT_LO_WR - `LOCK_LSB];
  assign b_ext_lo_rd = lock[`LOCK_EXT_LO_RD - `LOCK_LSB];
  assign b_ext_all   = lock[`LOCK_EXT_ALL - `LOCK_LSB];

  // Address windows
  assign std_upper = !ext_sel && (ram_addr >= `STD_UPPER_BASE) &&
                     (ram_addr <= `STD_UPPER_TOP);
  assign ext_low   = ext_sel && (ram_addr <= `EXT_LOW_TOP);

  // Any blocking bit wins, so terms are simply OR-ed
  assign write_ok = !(b_all_wr
                    || (std_upper && b_std)
                    || (ext_low && b_ext_lo_wr)
                    || (ext_sel && b_ext_all));
  assign read_ok  = !((std_upper && b_std)
                    || (ext_low && b_ext_lo_rd)
                    || (ext_sel && b_ext_all));

endmodule // rtc_ram_guard
`default_nettype wire

// ### logic/rtc_host_config.v
// Clock device configuration bank with RAM lock gating
`timescale 1ns/10ps
`default_nettype none
`include "rtc_cfg_map.vh"

module rtc_host_config (
  // Clock and reset
  input  wire       mclk,
  input  wire       rst,
  // Index-data configuration port
  input  wire [7:0] cfg_index,
  input  wire [7:0] cfg_wdata,
  input  wire       cfg_wr,
  input  wire       cfg_rd,
  output reg  [7:0] cfg_rdata,
  // Host RAM port, standard or extended bank
  input  wire       ram_ext_sel,
  input  wire [6:0] ram_addr,
  input  wire [7:0] ram_wdata,
  input  wire       ram_wr,
  input  wire       ram_rd,
  output reg  [7:0] ram_rdata,
  // Gated RAM store side
  output wire       store_wr,
  output wire       store_ext_sel,
  output wire [6:0] store_addr,
  output wire [7:0] store_wdata,
  input  wire [7:0] store_rdata,
  // Configuration for the clock core and decoder
  output reg  [7:0] device_activate,
  output wire [15:0] port0_base,
  output wire [15:0] port1_base,
  output reg  [7:0] irq_number_wake,
  output reg  [7:0] irq_type_select,
  output reg  [6:0] day_alarm_index,
  output reg  [6:0] month_alarm_index
);

  reg  [7:0] logical_unit_select;
  reg  [7:0] port0_base_high;
  reg  [6:0] port0_base_low;    // Bit 0 not stored
  reg  [7:0] port1_base_high;
  reg  [6:0] port1_base_low;
  reg  [4:0] nvram_access_lock; // Bits 7..3 only
  reg  [7:0] next_cfg_rdata;
  wire       bank_sel;
  wire       write_ok;
  wire       read_ok;
  wire       unit_wr;
  wire       bank_wr;
  wire       activate_wr;
  wire       p0_high_wr;
  wire       p0_low_wr;
  wire       p1_high_wr;
  wire       p1_low_wr;
  wire       irq_num_wr;
  wire       irq_type_wr;
  wire       lock_wr;
  wire       day_wr;
  wire       month_wr;

  // Bank visible only for the clock unit number
  assign bank_sel = (logical_unit_select == `UNIT_CLOCK);

  // Low base bits keep bit 0 at zero for 2-byte alignment
  assign port0_base = {port0_base_high, port0_base_low, 1'b0};
  assign port1_base = {port1_base_high, port1_base_low, 1'b0};

  rtc_ram_guard u_guard (
    .lock     (nvram_access_lock),
    .ext_sel  (ram_ext_sel),
    .ram_addr (ram_addr),
    .write_ok (write_ok),
    .read_ok  (read_ok)
  );

  // Blocked writes never reach the store
  assign store_wr      = ram_wr && write_ok;
  assign store_ext_sel = ram_ext_sel;
  assign store_addr    = ram_addr;
  assign store_wdata   = ram_wdata;

  // One strobe per register; unit select is always reachable
  assign unit_wr     = cfg_wr && (cfg_index == `IDX_UNIT_SELECT);
  assign bank_wr     = cfg_wr && bank_sel;
  assign activate_wr = bank_wr && (cfg_index == `IDX_ACTIVATE);
  assign p0_high_wr  = bank_wr && (cfg_index == `IDX_PORT0_HIGH);
  assign p0_low_wr   = bank_wr && (cfg_index == `IDX_PORT0_LOW);
  assign p1_high_wr  = bank_wr && (cfg_index == `IDX_PORT1_HIGH);
  assign p1_low_wr   = bank_wr && (cfg_index == `IDX_PORT1_LOW);
  assign irq_num_wr  = bank_wr && (cfg_index == `IDX_IRQ_NUMBER);
  assign irq_type_wr = bank_wr && (cfg_index == `IDX_IRQ_TYPE);
  assign lock_wr     = bank_wr && (cfg_index == `IDX_RAM_LOCK);
  assign day_wr      = bank_wr && (cfg_index == `IDX_DAY_ALARM);
  assign month_wr    = bank_wr && (cfg_index == `IDX_MONTH_ALARM);

  // Unit select is shared with the global control group
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      logical_unit_select <= `RST_UNIT_SELECT;
    end else if (unit_wr) begin
      logical_unit_select <= cfg_wdata;
    end
  end

  // Activate register, handed to the clock core as is
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      device_activate <= `RST_ACTIVATE;
    end else if (activate_wr) begin
      device_activate <= cfg_wdata;
    end
  end

  // Port 0 base, high byte
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      port0_base_high <= `RST_PORT0_HIGH;
    end else if (p0_high_wr) begin
      port0_base_high <= cfg_wdata;
    end
  end

  // Port 0 base, low byte; bit 0 has no flop, so it cannot drift
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      port0_base_low <= `RST_PORT0_STORED;
    end else if (p0_low_wr) begin
      port0_base_low <= cfg_wdata[7:1];
    end
  end

  // Port 1 base, high byte
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      port1_base_high <= `RST_PORT1_HIGH;
    end else if (p1_high_wr) begin
      port1_base_high <= cfg_wdata;
    end
  end

  // Port 1 base, low byte, same alignment as port 0
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      port1_base_low <= `RST_PORT1_STORED;
    end else if (p1_low_wr) begin
      port1_base_low <= cfg_wdata[7:1];
    end
  end

  // Interrupt number and wake enable
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_number_wake <= `RST_IRQ_NUMBER;
    end else if (irq_num_wr) begin
      irq_number_wake <= cfg_wdata;
    end
  end

  // Interrupt type select
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_type_select <= `RST_IRQ_TYPE;
    end else if (irq_type_wr) begin
      irq_type_select <= cfg_wdata;
    end
  end

  // Lock field; reserved low bits are never stored
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      nvram_access_lock <= `RST_RAM_LOCK;
    end else if (lock_wr) begin
      nvram_access_lock <= cfg_wdata[`LOCK_STD_UPPER:`LOCK_LSB];
    end
  end

  // Day alarm index; top bit reserved
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      day_alarm_index <= `RST_DAY_ALARM;
    end else if (day_wr) begin
      day_alarm_index <= cfg_wdata[6:0];
    end
  end

  // Month alarm index; top bit reserved
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      month_alarm_index <= `RST_MONTH_ALARM;
    end else if (month_wr) begin
      month_alarm_index <= cfg_wdata[6:0];
    end
  end

  // Read mux; unmapped or unselected indices read zero
  always @* begin
    next_cfg_rdata = `ZERO_BYTE;
    if (cfg_index == `IDX_UNIT_SELECT) begin
      next_cfg_rdata = logical_unit_select;
    end else if (bank_sel) begin
      case (cfg_index)
        `IDX_ACTIVATE:    next_cfg_rdata = device_activate;
        `IDX_PORT0_HIGH:  next_cfg_rdata = port0_base_high;
        `IDX_PORT0_LOW:   next_cfg_rdata = port0_base[7:0];
        `IDX_PORT1_HIGH:  next_cfg_rdata = port1_base_high;
        `IDX_PORT1_LOW:   next_cfg_rdata = port1_base[7:0];
        `IDX_IRQ_NUMBER:  next_cfg_rdata = irq_number_wake;
        `IDX_IRQ_TYPE:    next_cfg_rdata = irq_type_select;
        `IDX_RAM_LOCK:    next_cfg_rdata = {nvram_access_lock, 3'b000};
        `IDX_DAY_ALARM:   next_cfg_rdata = {1'b0, day_alarm_index};
        `IDX_MONTH_ALARM: next_cfg_rdata = {1'b0, month_alarm_index};
        default:          next_cfg_rdata = `ZERO_BYTE;
      endcase
    end
  end

  // Registered read data, captured on a read strobe
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_rdata <= `ZERO_BYTE;
      ram_rdata <= `ZERO_BYTE;
    end else begin
      if (cfg_rd) begin
        cfg_rdata <= next_cfg_rdata;
      end
      // Store read data is combinational for the current address
      if (ram_rd) begin
        ram_rdata <= read_ok ? store_rdata : `BLOCKED_READ;
      end
    end
  end

endmodule // rtc_host_config
`default_nettype wire

// ### bench/rtc_ram_store.sv
// RAM store model behind the lock filter
`timescale 1ns/10ps
`default_nettype none
module rtc_ram_store (
  // Clock
  input  wire logic       mclk,
  // Gated write and address
  input  wire logic       wr,
  input  wire logic       ext_sel,
  input  wire logic [6:0] addr,
  input  wire logic [7:0] wdata,
  // Combinational read data
  output logic      [7:0] rdata
);
  logic [7:0] mem [0:255];
  // Known contents so blocked and open reads differ
  initial for (int i = 0; i < 256; i++) mem[i] = 8'h00;
  // Only writes that pass the filter arrive here
  always @(posedge mclk) if (wr) mem[{ext_sel, addr}] <= wdata;
  assign rdata = mem[{ext_sel, addr}];
endmodule // rtc_ram_store
`default_nettype wire

// ### bench/rtc_host_config_monitor.sv
// Port checker for the configuration bank
`timescale 1ns/10ps
`default_nettype none
module rtc_host_config_monitor (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // Configuration port
  input wire logic        cfg_rd,
  input wire logic [7:0]  cfg_index,
  input wire logic [7:0]  cfg_rdata,
  // RAM port and store
  input wire logic        ram_rd,
  input wire logic        ram_wr,
  input wire logic        ram_ext_sel,
  input wire logic [6:0]  ram_addr,
  input wire logic [7:0]  ram_rdata,
  input wire logic        store_wr,
  input wire logic [7:0]  store_rdata,
  // Register outputs
  input wire logic [6:0]  day_alarm_index,
  input wire logic [6:0]  month_alarm_index,
  input wire logic [15:0] port0_base,
  input wire logic [15:0] port1_base
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_base_even_out: assert property (!port0_base[0] && !port1_base[0])
    else $error("port base bit 0 set");
  a_index_reset: assert property ($fell(rst) |->
    day_alarm_index == 7'h49 && month_alarm_index == 7'h4A)
    else $error("alarm index reset value wrong");
  a_std_low_open: assert property (ram_rd && !ram_ext_sel &&
    ram_addr < 7'h38 |=> ram_rdata == $past(store_rdata))
    else $error("open standard read altered");
  a_read_data_ff: assert property (ram_rd |=>
    ram_rdata == $past(store_rdata) || ram_rdata == 8'hFF)
    else $error("ram read neither data nor blocked");
  a_write_cause: assert property (store_wr |-> ram_wr)
    else $error("store write without host write");
  a_lock_reserved: assert property (cfg_rd && cfg_index == 8'hF0
    |=> cfg_rdata[2:0] == 3'h0)
    else $error("lock reserved bits not zero");
  a_alarm_top: assert property (cfg_rd && (cfg_index == 8'hF1 ||
    cfg_index == 8'hF2) |=> !cfg_rdata[7])
    else $error("alarm index top bit not zero");
  a_base_low_rd: assert property (cfg_rd && (cfg_index == 8'h61 ||
    cfg_index == 8'h63) |=> !cfg_rdata[0])
    else $error("base low bit 0 read set");
  a_unmapped_zero: assert property (cfg_rd && cfg_index == 8'h55
    |=> cfg_rdata == 8'h00)
    else $error("unmapped index read not zero");
  c_store_write: cover property (store_wr);
  c_blocked_read: cover property (ram_rd ##1 ram_rdata == 8'hFF);
  c_lock_read: cover property (cfg_rd && cfg_index == 8'hF0);
endmodule // rtc_host_config_monitor
bind rtc_host_config rtc_host_config_monitor mon_u (.mclk, .rst, .cfg_rd,
  .ram_rd, .ram_wr, .ram_ext_sel, .store_wr, .cfg_index, .cfg_rdata,
  .ram_rdata, .store_rdata, .ram_addr, .day_alarm_index,
  .month_alarm_index, .port0_base, .port1_base);
`default_nettype wire

// ### bench/rtc_host_config_tb.sv
// Self-checking bench for the configuration bank
`timescale 1ns/10ps
`default_nettype none
module rtc_host_config_tb;
  logic mclk = 0, rst = 1, cfg_wr = 0, cfg_rd = 0, ram_wr = 0, ram_rd = 0;
  logic ram_ext_sel = 0, store_wr, store_ext_sel;
  logic [7:0] cfg_index = 0, cfg_wdata = 0, ram_wdata = 0, cfg_rdata;
  logic [7:0] ram_rdata, store_wdata, store_rdata, device_activate;
  logic [7:0] irq_number_wake, irq_type_select;
  logic [6:0] ram_addr = 0, store_addr, day_alarm_index, month_alarm_index;
  logic [15:0] port0_base, port1_base;
  int failures = 0, n_tests = 0;
  int m [0:255] = '{default: 0}, km [0:255] = '{default: 0};
  int ram [0:255] = '{default: 0};
  int idx [11] = '{7, 'h30, 'h60, 'h61, 'h62, 'h63, 'h70, 'h71, 'hF0,
                   'hF1, 'hF2};
  int msk [11] = '{'hFF, 'hFF, 'hFF, 'hFE, 'hFF, 'hFE, 'hFF, 'hFF, 'hF8,
                   'h7F, 'h7F};
  int lk [8] = '{0, 'h80, 'h40, 'h20, 'h10, 'h08, 'hF8, 0};
  int ad [7] = '{0, 'h1F, 'h20, 'h37, 'h38, 'h3F, 'h7F};
  rtc_host_config dut_u (.mclk, .rst, .cfg_index, .cfg_wdata, .cfg_wr,
    .cfg_rd, .cfg_rdata, .ram_ext_sel, .ram_addr, .ram_wdata, .ram_wr,
    .ram_rd, .ram_rdata, .store_wr, .store_ext_sel, .store_addr,
    .store_wdata, .store_rdata, .device_activate, .port0_base, .port1_base,
    .irq_number_wake, .irq_type_select, .day_alarm_index,
    .month_alarm_index);
  rtc_ram_store store_u (.mclk, .wr(store_wr), .ext_sel(store_ext_sel),
    .addr(store_addr), .wdata(store_wdata), .rdata(store_rdata));
  initial forever #12.5 mclk = ~mclk;
  task automatic chk(input logic [7:0] got, input int exp);
    n_tests++;
    if (got !== exp[7:0]) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got,
               exp[7:0]);
    end
  endtask
  // Model keeps unit select writes always, other writes only when the bank is selected
  task automatic cw(input int i, d);
    @(negedge mclk);
    cfg_index = i;
    cfg_wdata = d;
    cfg_wr = 1;
    @(negedge mclk) cfg_wr = 0;
    if (i == 7 || m[7] == 'h10) m[i] = d & km[i];
  endtask
  task automatic cr(input int i);
    @(negedge mclk);
    cfg_index = i;
    cfg_rd = 1;
    @(negedge mclk) cfg_rd = 0;
    chk(cfg_rdata, (i == 7 || m[7] == 'h10) ? m[i] : 0);
  endtask
  // Any blocking bit wins over the others
  function automatic bit blk(bit e, bit w, int a);
    int k = m['hF0];
    return (w && k[6]) || (!e && a >= 'h38 && a <= 'h3F && k[7]) ||
           (e && k[3]) || (e && a < 'h20 && (w ? k[5] : k[4]));
  endfunction
  // Write a random byte, then read it back next cycle
  task automatic rwr(input bit e, input int a);
    @(negedge mclk);
    ram_ext_sel = e;
    ram_addr = a;
    ram_wdata = $urandom;
    ram_wr = 1;
    @(negedge mclk) ram_wr = 0;
    ram_rd = 1;
    if (!blk(e, 1, a)) ram[e * 128 + a] = ram_wdata;
    @(negedge mclk) ram_rd = 0;
    chk(ram_rdata, blk(e, 0, a) ? 'hFF : ram[e * 128 + a]);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    foreach (idx[i]) km[idx[i]] = msk[i];
    m['h61] = 'h70;
    m['h63] = 'h72;
    m['h70] = 'h08;
    m['hF1] = 'h49;
    m['hF2] = 'h4A;
    void'($urandom(70));
    repeat (10) @(negedge mclk);
    rst = 0;
    cw('hF1, 'h12);
    cr('hF1);
    cw(7, 'h10);
    foreach (idx[i]) cr(idx[i]);
    for (int n = 0; n < 4; n++) foreach (idx[i]) if (i) begin
      cw(idx[i], $urandom);
      cr(idx[i]);
    end
    cw('h55, 'hA5);
    cr('h55);
    chk(port1_base[7:0], m['h63]);
    chk(day_alarm_index, m['hF1]);
    chk(month_alarm_index, m['hF2]);
    chk(device_activate, m['h30]);
    chk(port0_base[15:8], m['h60]);
    chk(port0_base[7:0], m['h61]);
    chk(port1_base[15:8], m['h62]);
    chk(irq_number_wake, m['h70]);
    chk(irq_type_select, m['h71]);
    foreach (lk[j]) begin
      cw('hF0, lk[j]);
      foreach (ad[a]) for (int e = 0; e < 2; e++) rwr(e, ad[a]);
    end
    cw(7, 'h11);
    cw('hF1, 'h05);
    cw(7, 'h10);
    cr('hF1);
    summarize;
  end
  initial begin
    #(25 * 20000);
    failures++;
    summarize;
  end
endmodule // rtc_host_config_tb
`default_nettype wire
